// ### src/zlo_pkg.sv
// Purpose: Shared constants and types of the zoom oscillator control block.
// Assumes: One 25 MHz APB clock; all register offsets are byte addresses.
// Notes:   Frequencies are signed counts of 1/(1024*10^9) of the sample rate.

package zlo_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int NULL_TIME_NS = 100000;
   // Least time, so rounded up to whole cycles
   localparam int NULL_CYCLES =
      (NULL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NULL_CNT_W = 12;

   // ------------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------------
   localparam int FREQ_W = 40;
   localparam int REQ_W = 48;
   localparam int REQ_FRAC = 8;
   localparam int OFS_W = 16;
   localparam int SEL_W = 4;
   localparam int TABLE_N = 16;

   // ------------------------------------------------------------------
   // Frequency range and phase modulus
   // ------------------------------------------------------------------
   localparam logic signed [FREQ_W:0] FREQ_MAX = 41'h077_3594_0000;
   localparam logic signed [FREQ_W:0] FREQ_MIN = 41'h188_CA6C_0000;
   localparam logic signed [FREQ_W+1:0] PHASE_MOD = 42'h0EE_6B28_0000;
   localparam logic signed [REQ_W:0] ROUND_HALF = 49'h0_0000_0000_0080;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FREQ_LO = 8'h04;
   localparam logic [7:0] ADDR_FREQ_HI = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_PHASE = 8'h10;
   localparam logic [7:0] ADDR_OFFSET = 8'h14;
   localparam logic [7:0] ADDR_CORR = 8'h18;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int CTRL_KEEP_BIT = 0;
   localparam int CTRL_DEFER_BIT = 1;
   localparam int CTRL_NULL_BIT = 2;
   localparam int STAT_PEND_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_LOST_BIT = 2;
   localparam logic [FREQ_W-1:0] FREQ_RST = 40'h00_0000_0000;
   localparam logic [REQ_W-1:0] REQ_RST = 48'h0000_0000_0000;
   localparam logic [OFS_W-1:0] OFS_RST = 16'h0000;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef struct packed {
      logic keep_phase;
      logic defer;
   } zlo_ctrl_t;

   typedef struct packed {
      logic [FREQ_W-1:0] freq;
      logic [FREQ_W-1:0] phase;
   } zlo_osc_t;

   typedef enum logic [2:0] {
      ZLO_IDLE = 3'b001,
      ZLO_SETTLE = 3'b010,
      ZLO_STORE = 3'b100
   } zlo_null_t;

endpackage : zlo_pkg

// ### src/zlo_phase_acc.sv
// Purpose: Phase accumulator of the digital oscillator, modulo one turn.
// Assumes: Increment lies within plus or minus half a turn.
// Notes:   A clear forces phase zero on the next edge.

`timescale 1ns/100ps
`default_nettype none

module zlo_phase_acc import zlo_pkg::*; (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic [FREQ_W-1:0] freq,
   input wire logic clr,
   // Phase
   output logic [FREQ_W-1:0] phase
);

   logic signed [FREQ_W+1:0] sum;
   logic signed [FREQ_W+1:0] wrapped;
   logic [FREQ_W-1:0] next_phase;

   // Turn has 1024*10^9 steps, not a power of two, so wrap explicitly
   assign sum = $signed({2'b00, phase}) +
                $signed({{2{freq[FREQ_W-1]}}, freq});
   assign wrapped = (sum < 0) ? sum + PHASE_MOD :
                    (sum >= PHASE_MOD) ? sum - PHASE_MOD : sum;
   assign next_phase = wrapped[FREQ_W-1:0];

   // Accumulate every sample clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= FREQ_RST;
      end else if (clr) begin
         phase <= FREQ_RST;
      end else begin
         phase <= next_phase;
      end
   end

   chk_phase_in_turn: assert property (
      @(posedge pclk) disable iff (!presetn)
      $signed({2'b00, phase}) < PHASE_MOD)
      else $error("phase left the turn");

endmodule : zlo_phase_acc

`default_nettype wire

// ### src/zlo_freq_ctrl.sv
// Purpose: Centre-frequency control of the zoom digital oscillator.
// Assumes: APB slave on pclk; alignment line is an asynchronous pin.
// Notes:   Zero wait states; unmapped addresses answer with pslverr.

`timescale 1ns/100ps
`default_nettype none

module zlo_freq_ctrl import zlo_pkg::*; (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Shared alignment line, asynchronous
   input wire logic align_line,
   // Input setup and measured DC from the datapath
   input wire logic [SEL_W-1:0] setup_sel,
   input wire logic [OFS_W-1:0] dc_measure,
   // Oscillator and offset outputs
   output zlo_osc_t osc,
   output logic [OFS_W:0] offset_total,
   output logic meas_abort
);

   // ------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------
   wire logic access = psel & penable;
   wire logic wr_en = access & pwrite;
   wire logic rd_setup = psel & ~penable & ~pwrite;
   wire logic hit_ctrl = (paddr == ADDR_CTRL);
   wire logic hit_lo = (paddr == ADDR_FREQ_LO);
   wire logic hit_hi = (paddr == ADDR_FREQ_HI);
   wire logic hit_stat = (paddr == ADDR_STATUS);
   wire logic hit_phase = (paddr == ADDR_PHASE);
   wire logic hit_ofs = (paddr == ADDR_OFFSET);
   wire logic hit_corr = (paddr == ADDR_CORR);
   wire logic addr_hit = hit_ctrl | hit_lo | hit_hi | hit_stat |
                         hit_phase | hit_ofs | hit_corr;

   // No wait states; error answer only in the access phase
   assign pready = 1'b1;
   assign pslverr = access & ~addr_hit;

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   zlo_ctrl_t ctrl;
   logic [31:0] req_lo;
   logic [FREQ_W-1:0] active_freq;
   logic [FREQ_W-1:0] pend_freq;
   logic [FREQ_W-1:0] osc_phase;
   logic pending;
   logic coherence_lost;
   logic [OFS_W-1:0] user_offset;
   logic [OFS_W-1:0] ofs_table [TABLE_N];
   zlo_null_t null_state;
   logic [NULL_CNT_W-1:0] null_cnt;
   logic [SEL_W-1:0] null_sel;
   logic align_meta;
   logic align_sync;
   logic align_prev;

   // ------------------------------------------------------------------
   // Request rounding and limiting
   // ------------------------------------------------------------------
   // The high word write commits the whole request
   wire logic commit = wr_en & hit_hi;
   wire logic [REQ_W-1:0] req_full = {pwdata[15:0], req_lo};
   wire logic signed [REQ_W:0] req_rnd =
      $signed({req_full[REQ_W-1], req_full}) + ROUND_HALF;
   wire logic signed [FREQ_W:0] req_steps = req_rnd[REQ_W:REQ_FRAC];
   // Out-of-range requests saturate at half the sample rate
   wire logic signed [FREQ_W:0] req_lim =
      (req_steps > FREQ_MAX) ? FREQ_MAX :
      (req_steps < FREQ_MIN) ? FREQ_MIN : req_steps;
   wire logic [FREQ_W-1:0] quant = req_lim[FREQ_W-1:0];

   // ------------------------------------------------------------------
   // Alignment line synchroniser and edge
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         align_meta <= 1'b0;
         align_sync <= 1'b0;
         align_prev <= 1'b0;
      end else begin
         align_meta <= align_line;
         align_sync <= align_meta;
         align_prev <= align_sync;
      end
   end

   wire logic align_rise = align_sync & ~align_prev;

   // ------------------------------------------------------------------
   // Frequency apply decision
   // ------------------------------------------------------------------
   wire logic apply_direct = commit & ~ctrl.defer;
   wire logic apply_sync = pending & align_rise;
   wire logic apply_undefer = pending & ~ctrl.defer;
   wire logic apply_any = apply_direct | apply_sync | apply_undefer;
   wire logic [FREQ_W-1:0] apply_val = apply_direct ? quant : pend_freq;
   wire logic null_start = wr_en & hit_ctrl & pwdata[CTRL_NULL_BIT] &
                           (null_state == ZLO_IDLE);
   // Phase clears on a move to zero with keep-phase off, or when nulling starts
   wire logic to_zero = (apply_val == FREQ_RST);
   wire logic phase_clr = (apply_any & to_zero & ~ctrl.keep_phase) |
                          null_start;

   // Control register; reset leaves both selections off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= '0;
      end else if (wr_en & hit_ctrl) begin
         ctrl.keep_phase <= pwdata[CTRL_KEEP_BIT];
         ctrl.defer <= pwdata[CTRL_DEFER_BIT];
      end
   end

   // Low request word and user offset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_lo <= REQ_RST[31:0];
         user_offset <= OFS_RST;
      end else begin
         if (wr_en & hit_lo) req_lo <= pwdata;
         if (wr_en & hit_ofs) user_offset <= pwdata[OFS_W-1:0];
      end
   end

   // Shadow and active frequency; a new deferred commit in the same
   // cycle as an alignment edge becomes the next pending value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_freq <= FREQ_RST;
         pend_freq <= FREQ_RST;
         pending <= 1'b0;
      end else begin
         if (apply_any) active_freq <= apply_val;
         if (commit) pend_freq <= quant;
         if (commit & ctrl.defer) begin
            pending <= 1'b1;
         end else if (apply_sync | apply_undefer) begin
            pending <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Oscillator phase
   // ------------------------------------------------------------------
   zlo_phase_acc u_phase (
      .pclk(pclk),
      .presetn(presetn),
      .freq(active_freq),
      .clr(phase_clr),
      .phase(osc_phase)
   );

   // One driver for the whole carrier, members filled by name
   assign osc = '{freq: active_freq, phase: osc_phase};

   // ------------------------------------------------------------------
   // Offset nulling sequence
   // ------------------------------------------------------------------
   wire logic null_done = (null_state == ZLO_SETTLE) &
      (null_cnt == NULL_CNT_W'(NULL_CYCLES - 1));

   // Settle for the nulling time, then store the measured offset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         null_state <= ZLO_IDLE;
         null_cnt <= '0;
         null_sel <= '0;
      end else begin
         unique case (null_state)
            ZLO_IDLE: begin
               null_cnt <= '0;
               if (null_start) begin
                  null_sel <= setup_sel;
                  null_state <= ZLO_SETTLE;
               end
            end
            ZLO_SETTLE: begin
               null_cnt <= null_cnt + 1'b1;
               if (null_done) null_state <= ZLO_STORE;
            end
            ZLO_STORE: begin
               null_state <= ZLO_IDLE;
            end
            default: begin
               null_state <= ZLO_IDLE;
            end
         endcase
      end
   end

   // Measurement is aborted when nulling begins
   assign meas_abort = null_start;

   // Sticky loss of coherence; a new loss wins over a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coherence_lost <= 1'b0;
      end else if (null_start) begin
         coherence_lost <= 1'b1;
      end else if (wr_en & hit_stat & pwdata[STAT_LOST_BIT]) begin
         coherence_lost <= 1'b0;
      end
   end

   // One correction per setup condition
   genvar gi;
   generate
      for (gi = 0; gi < TABLE_N; gi++) begin : g_ofs
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ofs_table[gi] <= OFS_RST;
            end else if ((null_state == ZLO_STORE) &&
                         (null_sel == SEL_W'(gi))) begin
               ofs_table[gi] <= dc_measure;
            end
         end
      end
   endgenerate

   // Correction of the active setup added to the user offset
   wire logic [OFS_W:0] next_offset =
      $signed({user_offset[OFS_W-1], user_offset}) +
      $signed({ofs_table[setup_sel][OFS_W-1], ofs_table[setup_sel]});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offset_total <= '0;
      end else begin
         offset_total <= next_offset;
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   // A waiting change shows its pending value, not the one in use
   wire logic [FREQ_W-1:0] shown_freq =
      pending ? pend_freq : active_freq;
   wire logic null_busy = (null_state != ZLO_IDLE);
   wire logic [31:0] rd_ctrl = {29'h0, null_busy, ctrl.defer,
                                ctrl.keep_phase};
   wire logic [31:0] rd_stat = {29'h0, coherence_lost, null_busy,
                                pending};
   wire logic [31:0] rd_hi = {{24{shown_freq[FREQ_W-1]}},
                              shown_freq[FREQ_W-1:32]};
   wire logic [31:0] rd_mux =
      hit_ctrl ? rd_ctrl :
      hit_lo ? shown_freq[31:0] :
      hit_hi ? rd_hi :
      hit_stat ? rd_stat :
      hit_phase ? osc.phase[FREQ_W-1:8] :
      hit_ofs ? {{16{user_offset[OFS_W-1]}}, user_offset} :
      hit_corr ? {{15{offset_total[OFS_W]}}, offset_total} : 32'h0;

   // Read data captured in the setup phase, held through the access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd_setup) begin
         prdata <= rd_mux;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_defer_commit;
      commit && ctrl.defer;
   endsequence

   sequence s_align_apply;
      pending && align_rise;
   endsequence

   chk_zero_phase_reset: assert property (
      apply_any && to_zero && !ctrl.keep_phase |=> osc.phase == FREQ_RST)
      else $error("phase not reset on move to zero");

   chk_zero_phase_kept: assert property (
      apply_any && to_zero && ctrl.keep_phase && !null_start
      |=> osc.phase == $past(u_phase.next_phase))
      else $error("phase reset despite keep-phase");

   chk_nonzero_continuous: assert property (
      apply_any && !to_zero && !null_start
      |=> osc.phase == $past(u_phase.next_phase))
      else $error("nonzero change broke phase");

   chk_direct_apply: assert property (
      commit && !ctrl.defer |=> active_freq == $past(quant) && !pending)
      else $error("immediate change not applied");

   chk_pending_holds: assert property (
      pending && ctrl.defer && !align_rise |=> $stable(active_freq))
      else $error("pending value applied early");

   chk_align_apply: assert property (
      s_defer_commit ##[1:8] s_align_apply
      |=> active_freq == $past(pend_freq))
      else $error("alignment did not apply shadow");

   chk_undefer_apply: assert property (
      pending && !ctrl.defer |=> !pending &&
      active_freq == $past(pend_freq))
      else $error("cleared deferral left change pending");

   chk_freq_range: assert property (
      $signed({active_freq[FREQ_W-1], active_freq}) <= FREQ_MAX &&
      $signed({active_freq[FREQ_W-1], active_freq}) >= FREQ_MIN)
      else $error("frequency out of range");

   chk_pending_read: assert property (
      rd_setup && hit_lo && pending |=> prdata == $past(pend_freq[31:0]))
      else $error("read did not show pending value");

   chk_null_abort: assert property (
      null_start |-> meas_abort ##1 (coherence_lost &&
      osc.phase == FREQ_RST))
      else $error("nulling left measurement or phase");

   chk_table_store: assert property (
      null_done |=> ##1 ofs_table[null_sel] == $past(dc_measure))
      else $error("offset table not updated");

endmodule : zlo_freq_ctrl

`default_nettype wire

// ### bench/zlo_align_model.sv
// Purpose: Master module that owns the shared alignment line.
// Assumes: Host requests a pulse with a one-cycle fire strobe.
// Notes:   Refuses to pulse until its own alignment-valid flag is up.

`timescale 1ns/100ps
`default_nettype none

module zlo_align_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Host command and status
   input wire logic fire,
   output logic valid,
   // Shared alignment line
   output logic align_line
);
   logic [3:0] hold;
   logic [3:0] age;

   // Held several cycles so every peer synchroniser catches it
   assign align_line = (hold != 4'h0);
   assign valid = (age == 4'hF);

   // Pulse length and settling age after reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold <= 4'h0;
         age <= 4'h0;
      end else begin
         if (age != 4'hF) age <= age + 4'h1;
         if (fire && valid) hold <= 4'h4;
         else if (hold != 4'h0) hold <= hold - 4'h1;
      end
   end
endmodule : zlo_align_model

`default_nettype wire

// ### bench/tb_top.sv
// Purpose: Self-checking bench of the zoom oscillator frequency control.
// Assumes: Zero or more APB wait states; alignment from the master model.
// Notes:   Expected values are step counts worked out from request format.

`timescale 1ns/100ps
`default_nettype none

module tb_top import zlo_pkg::*; ;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic fire = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic align_line;
   logic valid;
   logic meas_abort;
   logic [SEL_W-1:0] setup_sel = 4'h3;
   logic [OFS_W-1:0] dc_measure = 16'h0010;
   zlo_osc_t osc;
   logic [OFS_W:0] offset_total;
   int miscompares = 0;
   int checked = 0;
   int cyc = 0;
   int abort_cnt = 0;
   int a0;
   logic [31:0] q;
   logic e;
   logic [FREQ_W-1:0] p;
   logic [47:0] reqs [6];
   logic [39:0] exps [6];
   // A quarter turn in steps; continuity keeps the phase residue
   localparam logic [39:0] QTURN = 40'h3B_9ACA_0000;

   zlo_freq_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .align_line(align_line), .setup_sel(setup_sel),
      .dc_measure(dc_measure), .osc(osc), .offset_total(offset_total),
      .meas_abort(meas_abort));

   zlo_align_model align_u (.pclk(pclk), .presetn(presetn), .fire(fire),
      .valid(valid), .align_line(align_line));

   // --------------------------------------------------------------
   // Clock, abort monitor and hang guard
   // --------------------------------------------------------------
   initial begin
      forever #20 pclk = ~pclk;
   end

   // Whole run is a few thousand cycles; nulling alone takes 2500
   always @(posedge pclk) begin
      cyc++;
      if (meas_abort === 1'b1) abort_cnt++;
      if (cyc == 20000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   // --------------------------------------------------------------
   // Tasks
   // --------------------------------------------------------------
   task automatic chk(input string nm, input logic [63:0] x,
                      input logic [63:0] g);
      checked++;
      if (g !== x) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, x, g);
      end
   endtask : chk

   // Request held until pready is seen high at the completing edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a,
                     input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, {32'h0, x}, {32'h0, q});
   endtask : rd

   // Low word first; the high write commits the request
   task automatic wf(input logic [47:0] r);
      wr(ADDR_FREQ_LO, r[31:0]);
      wr(ADDR_FREQ_HI, {16'h0000, r[47:32]});
   endtask : wf

   task automatic await(input logic [FREQ_W-1:0] x);
      int n;
      n = 0;
      @(negedge pclk);
      while (osc.freq !== x && n < 12) begin
         @(negedge pclk);
         n++;
      end
      chk("freq", {24'h0, x}, {24'h0, osc.freq});
   endtask : await

   task automatic pulse();
      @(posedge pclk);
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
   endtask : pulse

   task automatic tally_and_finish();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   // --------------------------------------------------------------
   // Main sequence
   // --------------------------------------------------------------
   initial begin
      reqs = '{48'h3B9A_CA00_0000, 48'h0000_0000_0580, 48'h0000_0000_057F,
               48'hFFFF_FFFF_FF00, 48'h7FFF_FFFF_FFFF, 48'h8000_0000_0000};
      exps = '{40'h3B_9ACA_0000, 40'h00_0000_0006, 40'h00_0000_0005,
               40'hFF_FFFF_FFFF, 40'h77_3594_0000, 40'h88_CA6C_0000};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctrl", ADDR_CTRL, 32'h0000_0000);
      rd("freq_lo", ADDR_FREQ_LO, 32'h0000_0000);
      rd("freq_hi", ADDR_FREQ_HI, 32'h0000_0000);
      chk("osc_freq", 64'h0, {24'h0, osc.freq});
      apb(1'b0, 8'hFC, 32'h0000_0000);
      chk("pslverr", 64'h1, {63'h0, e});
      $display("test reset and refusal done");
      // Immediate apply, rounding, negative image and clamping
      for (int i = 0; i < 6; i++) begin
         wf(reqs[i]);
         await(exps[i]);
         rd("rd_lo", ADDR_FREQ_LO, exps[i][31:0]);
         rd("rd_hi", ADDR_FREQ_HI, {{24{exps[i][39]}}, exps[i][39:32]});
      end
      $display("test immediate frequency done");
      // Keep-phase on a change to zero, then a nonzero change
      wf(reqs[0]);
      repeat (3) @(negedge pclk);
      wr(ADDR_CTRL, 32'h0000_0001);
      wf(48'h0000_0000_0000);
      await(40'h00_0000_0000);
      p = osc.phase;
      repeat (3) @(negedge pclk);
      chk("phase_kept", {24'h0, p}, {24'h0, osc.phase});
      chk("phase_live", 64'h1, {63'h0, p != 40'h0});
      wr(ADDR_CTRL, 32'h0000_0000);
      wf(reqs[0]);
      await(exps[0]);
      chk("phase_cont", {24'h0, p % QTURN}, {24'h0, osc.phase % QTURN});
      $display("test phase keep done");
      // Deferred change released by the alignment line, then by clearing the deferral
      rd("idle", ADDR_STATUS, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0002);
      wf(48'h1DCD_6500_0000);
      repeat (4) @(negedge pclk);
      chk("held", {24'h0, exps[0]}, {24'h0, osc.freq});
      rd("pend_lo", ADDR_FREQ_LO, 32'hCD65_0000);
      rd("status", ADDR_STATUS, 32'h0000_0001);
      while (valid !== 1'b1) @(posedge pclk);
      pulse();
      await(40'h1D_CD65_0000);
      wf(48'h0000_0000_0000);
      pulse();
      await(40'h00_0000_0000);
      @(negedge pclk);
      chk("phase_zero", 64'h0, {24'h0, osc.phase});
      rd("phase_rd", ADDR_PHASE, 32'h0000_0000);
      wf(reqs[0]);
      wr(ADDR_CTRL, 32'h0000_0000);
      await(exps[0]);
      $display("test deferred frequency done");
      // Offset nulling and its side effects
      wr(ADDR_OFFSET, 32'h0000_0005);
      rd("offset", ADDR_OFFSET, 32'h0000_0005);
      a0 = abort_cnt;
      wr(ADDR_CTRL, 32'h0000_0004);
      @(negedge pclk);
      chk("phase_null", 64'h0, {24'h0, osc.phase});
      chk("abort", 64'h1, 64'(abort_cnt - a0));
      rd("lost", ADDR_STATUS, 32'h0000_0006);
      do apb(1'b0, ADDR_STATUS, 32'h0); while (q[STAT_BUSY_BIT] !== 1'b0);
      chk("total", 64'h15, {47'h0, offset_total});
      rd("corr", ADDR_CORR, 32'h0000_0015);
      @(posedge pclk);
      setup_sel <= 4'h4;
      repeat (3) @(negedge pclk);
      chk("total_other", 64'h5, {47'h0, offset_total});
      wr(ADDR_STATUS, 32'h0000_0004);
      rd("lost_clr", ADDR_STATUS, 32'h0000_0000);
      $display("test offset nulling done");
      tally_and_finish();
   end
endmodule : tb_top

`default_nettype wire
